/* File: tb_top.sv */
// self-checking bench for the bonded fabric clocking top
`timescale 1ns/10ps
`include "xbfc_defines.vh"
module tb_top;
   reg clk_i = 1'b0, srst_i = 1'b1, bond = 1'b0, pcie = 1'b0;
   reg gen2 = 1'b0, hcore = 1'b0, bdes = 1'b0, rmatch = 1'b0;
   reg user = 1'b0, stall = 1'b0, wvalid = 1'b0, ce = 1'b1;
   reg [7:0] wdata = 8'h00, bits = 8'h00;
   reg [11:0] rsel = 12'h000;
   reg [4:0] refs = 5'h00;
   reg [127:0] cfg = 128'h0;
   wire rdy, fvalid, fready, fixt, calt, txt;
   wire [7:0] fword, ser, al, rd, pcf, got_cnt, rmw, txw;
   wire [3:0] ract;
   wire [23:0] ptr;
   wire [1:0] fclk, ident;
   wire [15:0] txs, rxs;
   wire [9:0] par, fab;
   int errors = 0, samples_checked = 0, i;
   int n_ser = 0, n_al = 0, n_rd0 = 0, n_rd4 = 0, n_pcf7 = 0;
   int n_rmw = 0, n_txw = 0;
   xbfc_top dut (.clk_i(clk_i), .srst_i(srst_i), .ce_i(ce),
      .bond_x8_i(bond), .pcie_mode_i(pcie), .pcie_gen2_i(gen2),
      .hard_core_en_i(hcore), .byte_deser_en_i(bdes),
      .rate_match_en_i(rmatch), .user_wrclk_en_i(user), .ref_sel_i(rsel),
      .block_ref_pin_a_i(refs[0]), .block_ref_pin_b_i(refs[1]),
      .inter_block_clock_net_i(refs[2]), .fab_clk_pin_i(refs[3]),
      .fab_pll_i(refs[4]), .rx_bit_tick_i(bits), .chan_cfg_i(cfg),
      .user_tx_clk_tick_i(txt), .fixed_clk_tick_i(fixt),
      .cal_clk_tick_i(calt), .rx_word_valid_i(wvalid), .rx_word_i(wdata),
      .fab_ready_i(fready), .rx_word_ready_o(rdy), .rx_fab_valid_o(fvalid),
      .rx_fab_word_o(fword), .ref_act_o(ract), .ser_clk_en_o(ser),
      .aligner_en_o(al), .rm_wr_en_o(rmw), .rm_rd_en_o(rd), .decoder_en_o(),
      .bdes_wr_en_o(), .rx_pcf_wr_en_o(pcf), .rx_pcf_wptr_o(ptr),
      .fab_if_clk_o(fclk), .tx_wr_src_o(txs), .tx_pcf_wr_en_o(txw),
      .rx_rd_src_o(rxs), .blk_ident_o(ident), .par_clk_mhz_o(par),
      .fab_clk_mhz_o(fab), .rx_detect_en_o(), .cal_en_o());
   xbfc_fab_model u_fab (.clk_i(clk_i), .srst_i(srst_i), .stall_i(stall),
      .fab_clk_i(fclk[0]), .valid_i(fvalid), .word_i(fword),
      .ready_o(fready), .fixed_tick_o(fixt), .cal_tick_o(calt),
      .tx_tick_o(txt), .got_cnt_o(got_cnt));
   initial forever #10 clk_i = ~clk_i;
   always @(negedge clk_i) begin
      n_ser += ser[0];
      n_al += al[0];
      n_rd0 += rd[0];
      n_rd4 += rd[4];
      n_pcf7 += pcf[7];
      n_rmw += rmw[0];
      n_txw += txw[0];
   end
   task cyc(input int n);
      repeat (n) @(posedge clk_i);
   endtask
   task chk(input [23:0] g, input [23:0] e);
      samples_checked++;
      if (g !== e) begin
         errors++;
         $display("ERROR %0t got %h expected %h", $time, g, e);
      end
   endtask
   task tally_and_finish;
      $display("errors %0d checks %0d", errors, samples_checked);
      if (errors == 0 && samples_checked > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   task do_reset;
      @(posedge clk_i);
      srst_i <= 1'b1;
      cyc(3);
      srst_i <= 1'b0;
   endtask
   // 15 ticks on the chosen refs and bit lines, then settle
   task run(input [4:0] m, input [7:0] b);
      {n_ser, n_al, n_rd0, n_rd4, n_pcf7, n_rmw, n_txw} = '0;
      @(posedge clk_i);
      refs <= m;
      bits <= b;
      cyc(15);
      refs <= 5'h00;
      bits <= 8'h00;
      cyc(6);
   endtask
   task push(input [7:0] w);
      int n;
      n = 0;
      @(posedge clk_i);
      wvalid <= 1'b1;
      wdata <= w;
      do begin
         @(posedge clk_i);
         n++;
      end while (!rdy && n < 100);
      chk(24'(rdy), 24'h1);
      wvalid <= 1'b0;
   endtask
   initial begin
      #200000;
      errors++;
      $display("ERROR %0t watchdog expired", $time);
      tally_and_finish;
   end
   initial begin
      cyc(3);
      chk(24'(par), 24'(`XBFC_MHZ_250));
      srst_i <= 1'b0;
      for (i = 0; i < 6; i++) begin
         @(posedge clk_i);
         rsel <= {4{3'(i)}};
         @(posedge clk_i);
         refs <= 5'(1 << i);
         @(posedge clk_i);
         refs <= 5'h00;
         #1 chk(24'(ract), (i < 5) ? 24'hf : 24'h0);
      end
      do_reset;
      run(5'h00, 8'hff);
      chk(24'(n_ser), 24'd7);
      chk(24'(n_al), 24'd1);
      chk(24'(n_rmw), 24'd1);
      ce <= 1'b0;
      run(5'h00, 8'hff);
      chk(24'(n_ser), 24'd0);
      ce <= 1'b1;
      bond <= 1'b1;
      pcie <= 1'b1;
      rsel <= 12'h008;
      run(5'h01, 8'h00);
      chk(24'(n_rd0), 24'd3);
      chk(24'(n_rd4), 24'd3);
      chk(24'(n_pcf7), 24'd3);
      chk(24'(n_txw), 24'd3);
      chk(ptr, {8{3'h3}});
      chk(24'(fclk), 24'h3);
      run(5'h02, 8'h00);
      chk(24'(n_rd4), 24'd0);
      bond <= 1'b0;
      run(5'h02, 8'h00);
      chk(24'(n_rd4), 24'd3);
      chk(24'(n_rd0), 24'd0);
      do_reset;
      bond <= 1'b1;
      bdes <= 1'b1;
      run(5'h01, 8'h00);
      chk(24'(n_pcf7), 24'd1);
      chk(24'(fclk), 24'h3);
      for (i = 0; i < 8; i++) begin
         @(posedge clk_i);
         gen2 <= i[0];
         bdes <= i[1];
         hcore <= i[2];
         cyc(2);
         chk(24'(par), 24'(i[0] ? `XBFC_MHZ_500 : `XBFC_MHZ_250));
         chk(24'(fab), 24'(i == 2 ? `XBFC_MHZ_125 : `XBFC_MHZ_250));
      end
      bond <= 1'b0;
      cfg <= {{2{16'h1200}}, 16'h3400, {3{16'h1200}}, 16'h12ab, 16'h1200};
      cyc(2);
      chk(24'(txs), 24'h0054);
      chk(24'(ident), 24'h1);
      user <= 1'b1;
      cyc(2);
      chk(24'(txs), 24'hffff);
      user <= 1'b0;
      bond <= 1'b1;
      cyc(2);
      chk(24'(txs), 24'haaaa);
      chk(24'(rxs), 24'h0000);
      rmatch <= 1'b1;
      cyc(2);
      chk(24'(rxs), 24'haaaa);
      bond <= 1'b0;
      cyc(2);
      chk(24'(rxs), 24'h5555);
      bond <= 1'b1;
      stall <= 1'b1;
      push(8'ha1);
      push(8'hb2);
      fork
         push(8'hc3);
         begin
            cyc(4);
            chk(24'(rdy), 24'h0);
            stall <= 1'b0;
            refs <= 5'h01;
         end
      join
      cyc(60);
      refs <= 5'h00;
      chk(24'(got_cnt), 24'd3);
      for (i = 0; i < 3; i++)
         chk(24'(u_fab.got[i]), 24'(8'ha1 + 8'(8'h11 * i)));
      tally_and_finish;
   end
endmodule // tb_top

/* File: xbfc_buf.v */
// two-entry buffer with valid and ready on both sides
`timescale 1ns/10ps
`include "xbfc_defines.vh"
module xbfc_buf (
   input wire clk_i,
   input wire srst_i,
   input wire ce_i,
   input wire in_valid_i,
   input wire [`XBFC_DATA_W-1:0] in_data_i,
   output wire in_ready_o,
   output wire out_valid_o,
   output wire [`XBFC_DATA_W-1:0] out_data_o,
   input wire out_ready_i
);
   reg [`XBFC_DATA_W-1:0] mem_ff [0:1];
   reg wr_ptr_ff;
   reg rd_ptr_ff;
   reg [1:0] cnt_ff;
   reg ready_ff;
   wire push;
   wire pop;
   reg [1:0] nxt_cnt;

   assign push = in_valid_i & ready_ff;
   assign pop = out_ready_i & (cnt_ff != 2'h0);
   assign in_ready_o = ready_ff;
   assign out_valid_o = (cnt_ff != 2'h0);
   assign out_data_o = mem_ff[rd_ptr_ff];

   always @* begin
      nxt_cnt = cnt_ff;
      if (push & ~pop) begin
         nxt_cnt = cnt_ff + 2'h1;
      end else if (pop & ~push) begin
         nxt_cnt = cnt_ff - 2'h1;
      end
   end

   always @(posedge clk_i) begin
      if (srst_i) begin
         wr_ptr_ff <= 1'b0;
         rd_ptr_ff <= 1'b0;
         cnt_ff <= 2'h0;
         ready_ff <= 1'b1;
         mem_ff[0] <= {`XBFC_DATA_W{1'b0}};
         mem_ff[1] <= {`XBFC_DATA_W{1'b0}};
      end else if (ce_i) begin
         if (push) begin
            mem_ff[wr_ptr_ff] <= in_data_i;
            wr_ptr_ff <= ~wr_ptr_ff;
         end
         if (pop) begin
            rd_ptr_ff <= ~rd_ptr_ff;
         end
         cnt_ff <= nxt_cnt;
         ready_ff <= (nxt_cnt != 2'h2);
      end
   end
endmodule // xbfc_buf

/* File: xbfc_defines.vh */
// named constants for the bonded fabric clocking block
`ifndef XBFC_DEFINES_VH
`define XBFC_DEFINES_VH

`define XBFC_NCH 8
`define XBFC_NBLK 2
`define XBFC_CH_PER_BLK 4
`define XBFC_MASTER_BLK 0

`define XBFC_CNT_W 3
`define XBFC_SER_DIV 3'h2
`define XBFC_PAR_DIV 3'h5
`define XBFC_LS_DIV 3'h5

`define XBFC_PTR_W 3
`define XBFC_DATA_W 8
`define XBFC_CFG_W 16
`define XBFC_IDENT_MASK 16'hff00

`define XBFC_REF_SEL_W 3
`define XBFC_REF_PIN_A 3'h0
`define XBFC_REF_PIN_B 3'h1
`define XBFC_REF_INTER_BLK 3'h2
`define XBFC_REF_FAB_PIN 3'h3
`define XBFC_REF_FAB_PLL 3'h4
`define XBFC_NREF_UNIT 4

`define XBFC_SRC_W 2
`define XBFC_TXW_OWN 2'h0
`define XBFC_TXW_CH0 2'h1
`define XBFC_TXW_SHARED 2'h2
`define XBFC_TXW_USER 2'h3
`define XBFC_RXR_RECOV 2'h0
`define XBFC_RXR_TX 2'h1
`define XBFC_RXR_SHARED 2'h2

`define XBFC_MHZ_W 10
`define XBFC_MHZ_125 10'h07d
`define XBFC_MHZ_250 10'h0fa
`define XBFC_MHZ_500 10'h1f4

`endif

/* File: xbfc_div.v */
// tick divider: one output tick per RATIO input ticks
`timescale 1ns/10ps
`include "xbfc_defines.vh"
module xbfc_div #(
   parameter [`XBFC_CNT_W-1:0] RATIO = `XBFC_PAR_DIV
) (
   input wire clk_i,
   input wire srst_i,
   input wire ce_i,
   input wire tick_i,
   output wire tick_o
);
   reg [`XBFC_CNT_W-1:0] cnt_ff;
   reg tick_ff;
   wire last;

   assign last = (cnt_ff == RATIO - 1'b1);
   assign tick_o = tick_ff;

   always @(posedge clk_i) begin
      if (srst_i) begin
         cnt_ff <= {`XBFC_CNT_W{1'b0}};
         tick_ff <= 1'b0;
      end else if (ce_i) begin
         tick_ff <= tick_i & last;
         if (tick_i) begin
            cnt_ff <= last ? {`XBFC_CNT_W{1'b0}} : cnt_ff + 1'b1;
         end
      end
   end
endmodule // xbfc_div

/* File: xbfc_fab_model.sv */
// fabric-side user logic: word capture and fabric-made clock ticks
`timescale 1ns/10ps
`include "xbfc_defines.vh"
module xbfc_fab_model (
   input wire clk_i,
   input wire srst_i,
   input wire stall_i,
   input wire fab_clk_i,
   input wire valid_i,
   input wire [`XBFC_DATA_W-1:0] word_i,
   output reg ready_o = 1'b0,
   output reg fixed_tick_o = 1'b0,
   output reg cal_tick_o = 1'b0,
   output reg tx_tick_o = 1'b0,
   output reg [7:0] got_cnt_o = 8'h00
);
   reg [`XBFC_DATA_W-1:0] got [0:7];
   reg [2:0] div_ff = 3'h0;
   reg fab_clk_ff = 1'b0;
   always @(posedge clk_i) begin
      ready_o <= !stall_i;
      fab_clk_ff <= fab_clk_i;
      // write tick taken from the forwarded clock, so no drift
      tx_tick_o <= !srst_i && (fab_clk_i ^ fab_clk_ff);
      div_ff <= div_ff + 3'h1;
      fixed_tick_o <= (div_ff[1:0] == 2'h3);
      cal_tick_o <= (div_ff == 3'h7);
      if (srst_i) begin
         got_cnt_o <= 8'h00;
      end else if (valid_i) begin
         got[got_cnt_o[2:0]] <= word_i;
         got_cnt_o <= got_cnt_o + 8'h01;
      end
   end
endmodule // xbfc_fab_model

/* File: xbfc_top.v */
// bonded receive clocking and fabric interface clock selection
`timescale 1ns/10ps
`include "xbfc_defines.vh"
// Notes on behaviour
// R1 - eight-lane bonding spans two four-channel blocks, block 0 master, 1 slave
// R2 - serial recovered clock is half line rate, divided to parallel clock
// R3 - own parallel recovered clock drives word aligner and rate-match write
// R4 - master low-speed clock drives rate-match read, decoder, byte-deser write
// R5 - phase FIFO write on low-speed clock or its half; also fabric clock
// R6 - PCIe eight-lane: all phase FIFOs use master channel 0 pointers
// R7 - PCIe eight-lane: 250 or 500 MHz coding clocks, 250 MHz fabric at gen2
// R8 - PCIe gen1 eight-lane with hard core gives 250 MHz fabric clock
// R9 - transmit fabric clock is per-channel, or shared clock when bonded
// R10 - receive read clock: recovered without rate match, else tx or shared
// R11 - fabric supplies fixed 125 MHz detect clock and calibration clock
// R12 - fabric transmit write clock matches device read clock exactly
// R13 - each PLL and recovery unit picks one of five reference sources
// R14 - identity ignores swing and pre-emphasis, compares all else
// R15 - without user write clock, transmit write clock chosen automatically
// R16 - four identical channels all use channel zero transmit clock
// R17 - fabric captures receive words on forwarded shared clock
module xbfc_top (
   input wire clk_i,
   input wire srst_i,
   input wire ce_i,
   input wire bond_x8_i,
   input wire pcie_mode_i,
   input wire pcie_gen2_i,
   input wire hard_core_en_i,
   input wire byte_deser_en_i,
   input wire rate_match_en_i,
   input wire user_wrclk_en_i,
   input wire [`XBFC_NREF_UNIT*`XBFC_REF_SEL_W-1:0] ref_sel_i,
   input wire block_ref_pin_a_i,
   input wire block_ref_pin_b_i,
   input wire inter_block_clock_net_i,
   input wire fab_clk_pin_i,
   input wire fab_pll_i,
   input wire [`XBFC_NCH-1:0] rx_bit_tick_i,
   input wire [`XBFC_NCH*`XBFC_CFG_W-1:0] chan_cfg_i,
   input wire user_tx_clk_tick_i,
   input wire fixed_clk_tick_i,
   input wire cal_clk_tick_i,
   input wire rx_word_valid_i,
   input wire [`XBFC_DATA_W-1:0] rx_word_i,
   input wire fab_ready_i,
   output wire rx_word_ready_o,
   output wire rx_fab_valid_o,
   output wire [`XBFC_DATA_W-1:0] rx_fab_word_o,
   output wire [`XBFC_NREF_UNIT-1:0] ref_act_o,
   output wire [`XBFC_NCH-1:0] ser_clk_en_o,
   output wire [`XBFC_NCH-1:0] aligner_en_o,
   output wire [`XBFC_NCH-1:0] rm_wr_en_o,
   output wire [`XBFC_NCH-1:0] rm_rd_en_o,
   output wire [`XBFC_NCH-1:0] decoder_en_o,
   output wire [`XBFC_NCH-1:0] bdes_wr_en_o,
   output wire [`XBFC_NCH-1:0] rx_pcf_wr_en_o,
   output wire [`XBFC_NCH*`XBFC_PTR_W-1:0] rx_pcf_wptr_o,
   output wire [`XBFC_NBLK-1:0] fab_if_clk_o,
   output wire [`XBFC_NCH*`XBFC_SRC_W-1:0] tx_wr_src_o,
   output wire [`XBFC_NCH-1:0] tx_pcf_wr_en_o,
   output wire [`XBFC_NCH*`XBFC_SRC_W-1:0] rx_rd_src_o,
   output wire [`XBFC_NBLK-1:0] blk_ident_o,
   output wire [`XBFC_MHZ_W-1:0] par_clk_mhz_o,
   output wire [`XBFC_MHZ_W-1:0] fab_clk_mhz_o,
   output wire rx_detect_en_o,
   output wire cal_en_o
);
   // pick one reference tick by source code
   function ref_pick;
      input [`XBFC_REF_SEL_W-1:0] sel;
      input [4:0] refs;
      begin
         case (sel)
            `XBFC_REF_PIN_A: ref_pick = refs[0];
            `XBFC_REF_PIN_B: ref_pick = refs[1];
            `XBFC_REF_INTER_BLK: ref_pick = refs[2];
            `XBFC_REF_FAB_PIN: ref_pick = refs[3];
            `XBFC_REF_FAB_PLL: ref_pick = refs[4];
            default: ref_pick = 1'b0;
         endcase
      end
   endfunction

   // channel configs equal once swing and pre-emphasis are masked
   function cfg_same;
      input [`XBFC_CFG_W-1:0] a;
      input [`XBFC_CFG_W-1:0] b;
      begin
         cfg_same = ((a & `XBFC_IDENT_MASK) == (b & `XBFC_IDENT_MASK)); // R14
      end
   endfunction

   wire [4:0] refs;
   wire [`XBFC_NREF_UNIT-1:0] ref_tick;
   wire [`XBFC_NBLK-1:0] ls_tick;
   wire [`XBFC_NCH-1:0] ser_tick;
   wire [`XBFC_NCH-1:0] par_tick;
   wire [`XBFC_NBLK-1:0] pcf_tick;
   wire [`XBFC_NBLK-1:0] blk_ident;
   wire buf_valid;
   wire [`XBFC_DATA_W-1:0] buf_data;
   wire buf_pop;
   wire rd_tick;

   reg [`XBFC_NREF_UNIT-1:0] ref_act_ff;
   reg [`XBFC_NBLK-1:0] half_ff;
   reg [`XBFC_NBLK-1:0] fab_clk_ff;
   reg [`XBFC_NCH-1:0] ser_en_ff;
   reg [`XBFC_NCH-1:0] aligner_ff;
   reg [`XBFC_NCH-1:0] rm_rd_ff;
   reg [`XBFC_NCH-1:0] pcf_wr_ff;
   reg [`XBFC_NCH*`XBFC_PTR_W-1:0] wptr_ff;
   reg [`XBFC_NCH*`XBFC_SRC_W-1:0] tx_src_ff;
   reg [`XBFC_NCH-1:0] tx_wr_ff;
   reg [`XBFC_NCH*`XBFC_SRC_W-1:0] rx_src_ff;
   reg [`XBFC_NBLK-1:0] ident_ff;
   reg [`XBFC_MHZ_W-1:0] par_mhz_ff;
   reg [`XBFC_MHZ_W-1:0] fab_mhz_ff;
   reg [`XBFC_MHZ_W-1:0] nxt_par_mhz;
   reg [`XBFC_MHZ_W-1:0] nxt_fab_mhz;
   reg det_ff;
   reg cal_ff;
   reg fab_vld_ff;
   reg [`XBFC_DATA_W-1:0] fab_word_ff;

   assign refs = {fab_pll_i, fab_clk_pin_i, inter_block_clock_net_i,
                  block_ref_pin_b_i, block_ref_pin_a_i};

   genvar gu;
   generate
      for (gu = 0; gu < `XBFC_NREF_UNIT; gu = gu + 1) begin : g_ref
         // units 0,1: block multipliers; units 2,3: block recovery refs
         assign ref_tick[gu] = ref_pick(
            ref_sel_i[gu*`XBFC_REF_SEL_W +: `XBFC_REF_SEL_W], refs); // R13
      end
   endgenerate

   genvar gb;
   generate
      for (gb = 0; gb < `XBFC_NBLK; gb = gb + 1) begin : g_blk
         // first multiplier divider of each block
         xbfc_div #(.RATIO(`XBFC_LS_DIV)) u_ls_div (
            .clk_i(clk_i),
            .srst_i(srst_i),
            .ce_i(ce_i),
            .tick_i(ref_tick[gb]),
            .tick_o(ls_tick[gb])
         );
         // phase FIFO write: every tick, or every other with byte deser
         assign pcf_tick[gb] = ls_tick[gb] &
                               (~byte_deser_en_i | half_ff[gb]); // R5
         assign blk_ident[gb] =
            cfg_same(chan_cfg_i[(gb*4+1)*`XBFC_CFG_W +: `XBFC_CFG_W],
                     chan_cfg_i[(gb*4)*`XBFC_CFG_W +: `XBFC_CFG_W]) &
            cfg_same(chan_cfg_i[(gb*4+2)*`XBFC_CFG_W +: `XBFC_CFG_W],
                     chan_cfg_i[(gb*4)*`XBFC_CFG_W +: `XBFC_CFG_W]) &
            cfg_same(chan_cfg_i[(gb*4+3)*`XBFC_CFG_W +: `XBFC_CFG_W],
                     chan_cfg_i[(gb*4)*`XBFC_CFG_W +: `XBFC_CFG_W]); // R14

         always @(posedge clk_i) begin
            if (srst_i) begin
               half_ff[gb] <= 1'b0;
               fab_clk_ff[gb] <= 1'b0;
               ident_ff[gb] <= 1'b0;
            end else if (ce_i) begin
               if (ls_tick[gb]) begin
                  half_ff[gb] <= ~half_ff[gb];
               end
               // slave follows master clock when bonded
               if (bond_x8_i) begin
                  fab_clk_ff[gb] <= fab_clk_ff[`XBFC_MASTER_BLK] ^
                                    pcf_tick[`XBFC_MASTER_BLK]; // R1 R5
               end else if (pcf_tick[gb]) begin
                  fab_clk_ff[gb] <= ~fab_clk_ff[gb]; // R5
               end
               ident_ff[gb] <= blk_ident[gb];
            end
         end
      end
   endgenerate

   genvar gc;
   generate
      for (gc = 0; gc < `XBFC_NCH; gc = gc + 1) begin : g_ch
         localparam BLK = gc / `XBFC_CH_PER_BLK;
         localparam C0 = BLK * `XBFC_CH_PER_BLK;
         wire ls_sel;
         wire pcf_sel;
         wire tx_tick;
         wire [`XBFC_PTR_W-1:0] own_ptr;

         // half-rate recovery then word-rate divide
         xbfc_div #(.RATIO(`XBFC_SER_DIV)) u_ser_div (
            .clk_i(clk_i),
            .srst_i(srst_i),
            .ce_i(ce_i),
            .tick_i(rx_bit_tick_i[gc]),
            .tick_o(ser_tick[gc])
         ); // R2
         xbfc_div #(.RATIO(`XBFC_PAR_DIV)) u_par_div (
            .clk_i(clk_i),
            .srst_i(srst_i),
            .ce_i(ce_i),
            .tick_i(ser_tick[gc]),
            .tick_o(par_tick[gc])
         ); // R2

         assign ls_sel = bond_x8_i ? ls_tick[`XBFC_MASTER_BLK]
                                   : ls_tick[BLK]; // R4
         assign pcf_sel = bond_x8_i ? pcf_tick[`XBFC_MASTER_BLK]
                                    : pcf_tick[BLK]; // R5
         // user clock assumed same rate, no rate compensation here
         assign tx_tick = user_wrclk_en_i ? user_tx_clk_tick_i : ls_sel; // R12
         assign own_ptr = wptr_ff[gc*`XBFC_PTR_W +: `XBFC_PTR_W];

         always @(posedge clk_i) begin
            if (srst_i) begin
               ser_en_ff[gc] <= 1'b0;
               aligner_ff[gc] <= 1'b0;
               rm_rd_ff[gc] <= 1'b0;
               pcf_wr_ff[gc] <= 1'b0;
               tx_wr_ff[gc] <= 1'b0;
               wptr_ff[gc*`XBFC_PTR_W +: `XBFC_PTR_W] <= {`XBFC_PTR_W{1'b0}};
               tx_src_ff[gc*`XBFC_SRC_W +: `XBFC_SRC_W] <= `XBFC_TXW_OWN;
               rx_src_ff[gc*`XBFC_SRC_W +: `XBFC_SRC_W] <= `XBFC_RXR_RECOV;
            end else if (ce_i) begin
               ser_en_ff[gc] <= ser_tick[gc]; // R2
               aligner_ff[gc] <= par_tick[gc]; // R3
               rm_rd_ff[gc] <= ls_sel; // R4
               pcf_wr_ff[gc] <= pcf_sel; // R5
               tx_wr_ff[gc] <= tx_tick; // R15
               if (pcie_mode_i & bond_x8_i) begin
                  // master channel 0 pointer shared by all eight
                  wptr_ff[gc*`XBFC_PTR_W +: `XBFC_PTR_W] <=
                     wptr_ff[0 +: `XBFC_PTR_W] + {2'h0, pcf_sel}; // R6
               end else begin
                  wptr_ff[gc*`XBFC_PTR_W +: `XBFC_PTR_W] <=
                     own_ptr + {2'h0, pcf_sel};
               end
               if (user_wrclk_en_i) begin
                  tx_src_ff[gc*`XBFC_SRC_W +: `XBFC_SRC_W] <= `XBFC_TXW_USER;
               end else if (bond_x8_i) begin
                  tx_src_ff[gc*`XBFC_SRC_W +: `XBFC_SRC_W] <=
                     `XBFC_TXW_SHARED; // R9 R15
               end else if (blk_ident[BLK]) begin
                  tx_src_ff[gc*`XBFC_SRC_W +: `XBFC_SRC_W] <=
                     (gc == C0) ? `XBFC_TXW_OWN : `XBFC_TXW_CH0; // R16
               end else begin
                  tx_src_ff[gc*`XBFC_SRC_W +: `XBFC_SRC_W] <=
                     `XBFC_TXW_OWN; // R9 R15
               end
               if (~rate_match_en_i) begin
                  rx_src_ff[gc*`XBFC_SRC_W +: `XBFC_SRC_W] <=
                     `XBFC_RXR_RECOV; // R10
               end else if (bond_x8_i) begin
                  rx_src_ff[gc*`XBFC_SRC_W +: `XBFC_SRC_W] <=
                     `XBFC_RXR_SHARED; // R10
               end else begin
                  rx_src_ff[gc*`XBFC_SRC_W +: `XBFC_SRC_W] <=
                     `XBFC_RXR_TX; // R10
               end
            end
         end
      end
   endgenerate

   // nominal frequencies of the bonded PCIe mode
   always @* begin
      nxt_par_mhz = `XBFC_MHZ_250; // R7
      nxt_fab_mhz = `XBFC_MHZ_250; // R8
      if (pcie_gen2_i) begin
         nxt_par_mhz = `XBFC_MHZ_500; // R7
         nxt_fab_mhz = `XBFC_MHZ_250; // R7
      end else if (byte_deser_en_i & ~hard_core_en_i) begin
         nxt_fab_mhz = `XBFC_MHZ_125;
      end
   end

   // receive words leave on the shared read clock tick when bonded, else on channel 0 low-speed or recovered tick
   assign rd_tick = bond_x8_i ? pcf_tick[`XBFC_MASTER_BLK]
                              : (rate_match_en_i ? ls_tick[0] : par_tick[0]);
   assign buf_pop = rd_tick & fab_ready_i; // R17

   xbfc_buf u_buf (
      .clk_i(clk_i),
      .srst_i(srst_i),
      .ce_i(ce_i),
      .in_valid_i(rx_word_valid_i),
      .in_data_i(rx_word_i),
      .in_ready_o(rx_word_ready_o),
      .out_valid_o(buf_valid),
      .out_data_o(buf_data),
      .out_ready_i(buf_pop)
   );

   always @(posedge clk_i) begin
      if (srst_i) begin
         ref_act_ff <= {`XBFC_NREF_UNIT{1'b0}};
         par_mhz_ff <= `XBFC_MHZ_250;
         fab_mhz_ff <= `XBFC_MHZ_250;
         det_ff <= 1'b0;
         cal_ff <= 1'b0;
         fab_vld_ff <= 1'b0;
         fab_word_ff <= {`XBFC_DATA_W{1'b0}};
      end else if (ce_i) begin
         ref_act_ff <= ref_tick; // R13
         par_mhz_ff <= nxt_par_mhz;
         fab_mhz_ff <= nxt_fab_mhz;
         det_ff <= fixed_clk_tick_i & pcie_mode_i; // R11
         cal_ff <= cal_clk_tick_i; // R11
         fab_vld_ff <= buf_valid & buf_pop; // R17
         if (buf_valid & buf_pop) begin
            fab_word_ff <= buf_data;
         end
      end
   end

   assign rx_fab_valid_o = fab_vld_ff;
   assign rx_fab_word_o = fab_word_ff;
   assign ref_act_o = ref_act_ff;
   assign ser_clk_en_o = ser_en_ff;
   assign aligner_en_o = aligner_ff;
   assign rm_wr_en_o = aligner_ff;
   assign rm_rd_en_o = rm_rd_ff;
   assign decoder_en_o = rm_rd_ff;
   assign bdes_wr_en_o = rm_rd_ff;
   assign rx_pcf_wr_en_o = pcf_wr_ff;
   assign rx_pcf_wptr_o = wptr_ff;
   assign fab_if_clk_o = fab_clk_ff;
   assign tx_wr_src_o = tx_src_ff;
   assign tx_pcf_wr_en_o = tx_wr_ff;
   assign rx_rd_src_o = rx_src_ff;
   assign blk_ident_o = ident_ff;
   assign par_clk_mhz_o = par_mhz_ff;
   assign fab_clk_mhz_o = fab_mhz_ff;
   assign rx_detect_en_o = det_ff;
   assign cal_en_o = cal_ff;
endmodule // xbfc_top

/* File: xbfc_top_assertions.sv */
// assertion checker on the bonded fabric clocking top ports
`timescale 1ns/10ps
`include "xbfc_defines.vh"
module xbfc_chk (
   input wire clk_i,
   input wire srst_i,
   input wire ce_i,
   input wire bond_x8_i,
   input wire pcie_mode_i,
   input wire pcie_gen2_i,
   input wire user_wrclk_en_i,
   input wire rate_match_en_i,
   input wire fixed_clk_tick_i,
   input wire cal_clk_tick_i,
   input wire cal_en_o,
   input wire rx_detect_en_o,
   input wire [`XBFC_NCH-1:0] rm_rd_en_o,
   input wire [`XBFC_NCH-1:0] decoder_en_o,
   input wire [`XBFC_NCH-1:0] bdes_wr_en_o,
   input wire [`XBFC_NCH*`XBFC_PTR_W-1:0] rx_pcf_wptr_o,
   input wire [`XBFC_NBLK-1:0] fab_if_clk_o,
   input wire [`XBFC_MHZ_W-1:0] par_clk_mhz_o,
   input wire [`XBFC_MHZ_W-1:0] fab_clk_mhz_o,
   input wire [`XBFC_NCH*`XBFC_SRC_W-1:0] tx_wr_src_o,
   input wire [`XBFC_NCH*`XBFC_SRC_W-1:0] rx_rd_src_o
);
   default clocking dcb @(posedge clk_i);
   endclocking
   default disable iff (srst_i);
   AST_RDET: assert property (rx_detect_en_o |->
      $past(fixed_clk_tick_i) && $past(pcie_mode_i))
      else $error("stray detect");
   AST_CAL: assert property ($past(ce_i) && !$past(srst_i) |->
      cal_en_o == $past(cal_clk_tick_i)) else $error("cal tick lost");
   AST_LS_EQ: assert property (decoder_en_o == rm_rd_en_o &&
      bdes_wr_en_o == rm_rd_en_o) else $error("low-speed enables split");
   AST_BOND_RD: assert property (bond_x8_i [*4] |->
      (rm_rd_en_o == 8'h00 || rm_rd_en_o == 8'hff)) else $error("x8 skew");
   AST_PTR: assert property ((pcie_mode_i && bond_x8_i) [*3] |->
      rx_pcf_wptr_o == {8{rx_pcf_wptr_o[2:0]}}) else $error("ptr split");
   AST_FAB_SHR: assert property (bond_x8_i [*4] |->
      fab_if_clk_o[1] == fab_if_clk_o[0]) else $error("fabric clk split");
   AST_MHZ: assert property ($past(ce_i) && !$past(srst_i) &&
      $past(pcie_gen2_i) |->
      par_clk_mhz_o == `XBFC_MHZ_500 && fab_clk_mhz_o == `XBFC_MHZ_250)
      else $error("gen2 rates wrong");
   AST_TXU: assert property ($past(ce_i) && !$past(srst_i) &&
      $past(user_wrclk_en_i) |-> tx_wr_src_o == {8{`XBFC_TXW_USER}})
      else $error("user clk not used");
   AST_RXR: assert property ($past(ce_i) && !$past(srst_i) &&
      !$past(rate_match_en_i) |-> rx_rd_src_o == 16'h0000)
      else $error("rx read clk not recovered");
endmodule // xbfc_chk
bind xbfc_top xbfc_chk u_chk (.clk_i(clk_i), .srst_i(srst_i), .ce_i(ce_i),
   .bond_x8_i(bond_x8_i), .pcie_mode_i(pcie_mode_i),
   .pcie_gen2_i(pcie_gen2_i), .user_wrclk_en_i(user_wrclk_en_i),
   .rate_match_en_i(rate_match_en_i), .fixed_clk_tick_i(fixed_clk_tick_i),
   .cal_clk_tick_i(cal_clk_tick_i), .cal_en_o(cal_en_o),
   .rx_detect_en_o(rx_detect_en_o), .rm_rd_en_o(rm_rd_en_o),
   .decoder_en_o(decoder_en_o), .bdes_wr_en_o(bdes_wr_en_o),
   .rx_pcf_wptr_o(rx_pcf_wptr_o), .fab_if_clk_o(fab_if_clk_o),
   .par_clk_mhz_o(par_clk_mhz_o), .fab_clk_mhz_o(fab_clk_mhz_o),
   .tx_wr_src_o(tx_wr_src_o), .rx_rd_src_o(rx_rd_src_o));
